// *** rtl/lbc_defs.svh ***
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH
`define LBC_ADDR_W      20
`define LBC_DATA_W      16
`define LBC_STAT_W      4
`define LBC_ADDR_HI_LSB 16
`define LBC_FIFO_DEPTH  16
`define LBC_CMD_W       38
`define LBC_CMD_WR_BIT  36
`define LBC_CMD_RF_BIT  37
`define LBC_AD0_BIT     0
`define LBC_LAT_LSB     1
`define LBC_LAT_MSB     2
`endif

// *** rtl/lbc_pkg.sv ***
package lbc_pkg;
  typedef enum logic [2:0] {
    LBC_IDLE = 3'b000,
    LBC_T1   = 3'b001,
    LBC_T2   = 3'b010,
    LBC_T3   = 3'b011,
    LBC_TW   = 3'b100,
    LBC_T4   = 3'b101
  } lbc_state_t;
  typedef enum logic [1:0] {
    LBC_XFER_WORD = 2'b00,
    LBC_XFER_EVEN = 2'b01,
    LBC_XFER_ODD  = 2'b10,
    LBC_XFER_RFSH = 2'b11
  } lbc_xfer_t;
endpackage

// *** rtl/lbc_sync.sv ***
`timescale 1ns/1ps
module lbc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  if (W < 1) begin : g_w_chk
    $error("lbc_sync width must be at least 1");
  end
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end
  assign o_q = s2_r;
endmodule

// *** rtl/lbc_fifo.sv ***
`timescale 1ns/1ps
module lbc_fifo #(
  parameter int W     = 38,
  parameter int DEPTH = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  if (W < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("lbc_fifo depth must be a power of two of at least 2");
  end
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic [AW:0]  wp_nxt;
  logic [AW:0]  rp_nxt;
  logic         push;
  logic         pop;
  always_comb begin
    o_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
    o_valid = wp_r != rp_r;
    push    = i_valid && o_ready;
    pop     = o_valid && i_ready;
    wp_nxt  = push ? wp_r + (AW+1)'(1) : wp_r;
    rp_nxt  = pop ? rp_r + (AW+1)'(1) : rp_r;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= i_data;
    end
  end
  assign o_data = mem_r[rp_r[AW-1:0]];
endmodule

// *** rtl/lbc_top.sv ***
`timescale 1ns/1ps
`include "lbc_defs.svh"
module lbc_top
  import lbc_pkg::*;
#(
  parameter int DEPTH = `LBC_FIFO_DEPTH
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_clkin,
  input  wire logic                    i_enhanced,
  input  wire logic                    i_latch_addr_mode,
  input  wire logic                    i_coproc_op,
  input  wire logic                    i_req_valid,
  output logic                         o_req_ready,
  input  wire logic [`LBC_ADDR_W-1:0]  i_req_addr,
  input  wire logic [`LBC_DATA_W-1:0]  i_req_wdata,
  input  wire logic                    i_req_write,
  input  wire logic                    i_req_refresh,
  input  wire logic [`LBC_STAT_W-1:0]  i_req_status,
  input  wire logic                    i_pcs5_int_n,
  input  wire logic                    i_pcs6_int_n,
  output logic                         o_rd_valid,
  output logic      [`LBC_DATA_W-1:0]  o_rd_data,
  output logic                         o_done,
  output logic                         o_stalled,
  output logic      [1:0]              o_dma_req,
  output logic                         o_clkout,
  output logic                         o_ale,
  output logic      [`LBC_DATA_W-1:0]  o_ad,
  output logic                         o_ad_oe_n,
  input  wire logic [`LBC_DATA_W-1:0]  i_ad,
  output logic      [`LBC_STAT_W-1:0]  o_upper_addr_status_pin,
  output logic                         o_bhe_n,
  output logic                         o_den_n,
  output logic                         o_transfer_direction,
  output logic                         o_peripheral_select_five_n,
  output logic                         o_peripheral_select_six_n,
  input  wire logic                    i_ardy,
  input  wire logic                    i_busy,
  input  wire logic                    i_dma_request_ch_zero,
  input  wire logic                    i_dma_request_ch_one
);
  if (DEPTH < 2) begin : g_depth_chk
    $error("lbc_top fifo depth too small");
  end

  logic [2:0] pin_s;
  logic       clkin_s;
  logic       ardy_s;
  logic       busy_s;
  lbc_sync #(.W(3)) u_pin_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    ({i_clkin, i_ardy, i_busy}),
    .o_q    (pin_s)
  );
  assign {clkin_s, ardy_s, busy_s} = pin_s;

  // The request pins are levels, so no edge capture is needed.
  lbc_sync #(.W(2)) u_dma_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    ({i_dma_request_ch_one, i_dma_request_ch_zero}),
    .o_q    (o_dma_req)
  );

  // Read data stands through T4, so two flops of delay cost nothing.
  logic [`LBC_DATA_W-1:0] ad_in_s;
  lbc_sync #(.W(`LBC_DATA_W)) u_ad_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    (i_ad),
    .o_q    (ad_in_s)
  );

  logic [`LBC_CMD_W-1:0] fifo_in;
  logic [`LBC_CMD_W-1:0] cmd;
  logic                  cmd_valid;
  logic                  cmd_take;
  assign fifo_in = {i_req_refresh, i_req_write, i_req_wdata, i_req_addr};
  lbc_fifo #(.W(`LBC_CMD_W), .DEPTH(DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (i_req_valid),
    .o_ready (o_req_ready),
    .i_data  (fifo_in),
    .o_valid (cmd_valid),
    .i_ready (cmd_take),
    .o_data  (cmd)
  );

  // Clock output toggles on each falling edge of the input clock; bus states advance only on falls while it is high.
  logic clkin_d_r;
  logic fall;
  logic clkout_r;
  logic clkout_nxt;
  always_comb begin
    fall       = clkin_d_r && !clkin_s;
    clkout_nxt = fall ? !clkout_r : clkout_r;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clkin_d_r <= 1'b0;
      clkout_r  <= 1'b0;
    end else begin
      clkin_d_r <= clkin_s;
      clkout_r  <= clkout_nxt;
    end
  end
  assign o_clkout = clkout_r;
  logic tick;
  assign tick = fall && clkout_r;

  lbc_state_t            st_r, st_nxt;
  logic [`LBC_CMD_W-1:0] cur_r, cur_nxt;
  logic [`LBC_DATA_W-1:0] rd_r, rd_nxt;
  logic                  rdv_r, rdv_nxt;
  logic                  done_r, done_nxt;
  logic                  stall_r, stall_nxt;
  logic [1:0]            lat_r, lat_nxt;
  logic                  is_wr;
  logic                  is_rf;
  lbc_xfer_t             xfer;
  logic                  bhe_n;
  logic                  addr_data_bit_zero;
  always_comb begin
    is_wr = cur_r[`LBC_CMD_WR_BIT];
    is_rf = cur_r[`LBC_CMD_RF_BIT] && i_enhanced;
    addr_data_bit_zero = cur_r[`LBC_AD0_BIT];
    // Requests carry no size, so every plain cycle enables the upper byte.
    bhe_n = 1'b0;
    if (is_rf) begin
      addr_data_bit_zero = 1'b1;
      bhe_n              = 1'b1;
    end
    xfer = lbc_xfer_t'({addr_data_bit_zero, bhe_n});
  end

  always_comb begin
    st_nxt    = st_r;
    cur_nxt   = cur_r;
    rd_nxt    = rd_r;
    rdv_nxt   = 1'b0;
    done_nxt  = 1'b0;
    cmd_take  = 1'b0;
    lat_nxt   = lat_r;
    // Busy only matters in enhanced mode for coprocessor work.
    stall_nxt = i_enhanced && i_coproc_op && busy_s;
    if (tick) begin
      unique case (st_r)
        LBC_IDLE: begin
          if (cmd_valid && !stall_r) begin
            cmd_take = 1'b1;
            cur_nxt  = cmd;
            st_nxt   = LBC_T1;
          end
        end
        LBC_T1: begin
          lat_nxt = cur_r[`LBC_LAT_MSB:`LBC_LAT_LSB];
          st_nxt  = LBC_T2;
        end
        LBC_T2: st_nxt = LBC_T3;
        LBC_T3, LBC_TW: begin
          st_nxt = ardy_s ? LBC_T4 : LBC_TW;
        end
        LBC_T4: begin
          if (!is_wr) begin
            rd_nxt  = ad_in_s;
            rdv_nxt = 1'b1;
          end
          done_nxt = 1'b1;
          st_nxt   = LBC_IDLE;
        end
        default: st_nxt = LBC_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r    <= LBC_IDLE;
      cur_r   <= '0;
      rd_r    <= '0;
      rdv_r   <= 1'b0;
      done_r  <= 1'b0;
      stall_r <= 1'b0;
      lat_r   <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      cur_r   <= cur_nxt;
      rd_r    <= rd_nxt;
      rdv_r   <= rdv_nxt;
      done_r  <= done_nxt;
      stall_r <= stall_nxt;
      lat_r   <= lat_nxt;
    end
  end
  assign o_rd_valid = rdv_r;
  assign o_rd_data  = rd_r;
  assign o_done     = done_r;
  assign o_stalled  = stall_r;

  // Pin outputs, except status outside T1, the selects outside latch mode and the refresh decode gated by i_enhanced, which follow inputs,
  // are decoded from registered state, so they hold steady between ticks and glitch only at state boundaries.
  logic in_cyc;
  logic data_ph;
  always_comb begin
    in_cyc  = st_r != LBC_IDLE;
    data_ph = st_r == LBC_T2 || st_r == LBC_T3 || st_r == LBC_TW ||
              st_r == LBC_T4;
    o_ale   = st_r == LBC_T1;
    o_upper_addr_status_pin = (st_r == LBC_T1) ?
      cur_r[`LBC_ADDR_W-1:`LBC_ADDR_HI_LSB] : i_req_status;
    o_ad = cur_r[`LBC_DATA_W-1:0];
    o_ad[`LBC_AD0_BIT] = addr_data_bit_zero;
    if (data_ph) begin
      o_ad = cur_r[`LBC_DATA_W+`LBC_ADDR_W-1:`LBC_ADDR_W];
    end
    o_ad_oe_n = !(st_r == LBC_T1 || (data_ph && is_wr) || is_rf && in_cyc);
    o_bhe_n   = in_cyc ? bhe_n : 1'b1;
    o_den_n   = !(data_ph && !is_rf);
    o_transfer_direction = in_cyc ? is_wr : 1'b0;
    if (i_latch_addr_mode) begin
      o_peripheral_select_five_n = lat_r[0];
      o_peripheral_select_six_n  = lat_r[1];
    end else begin
      o_peripheral_select_five_n = i_pcs5_int_n;
      o_peripheral_select_six_n  = i_pcs6_int_n;
    end
  end

  a_ale_t1_only: assert property (
    @(posedge i_clk) disable iff (i_srst)
    o_ale |-> st_r == LBC_T1 && o_den_n && !o_ad_oe_n)
    else $error("strobe outside address state");
  a_upper_addr: assert property (
    @(posedge i_clk) disable iff (i_srst)
    st_r == LBC_T1 |-> o_upper_addr_status_pin ==
      cur_r[`LBC_ADDR_W-1:`LBC_ADDR_HI_LSB])
    else $error("upper address wrong in T1");
  a_upper_status: assert property (
    @(posedge i_clk) disable iff (i_srst)
    data_ph |-> o_upper_addr_status_pin == i_req_status)
    else $error("upper pins not status");
  a_ready_gate: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (st_r == LBC_T3 || st_r == LBC_TW) && tick && !ardy_s
    |=> st_r == LBC_TW)
    else $error("cycle ended without ready");
  a_refresh_code: assert property (
    @(posedge i_clk) disable iff (i_srst)
    st_r == LBC_T1 && is_rf |->
      xfer == LBC_XFER_RFSH && o_bhe_n && o_ad[`LBC_AD0_BIT])
    else $error("refresh code wrong");
  a_word_code: assert property (
    @(posedge i_clk) disable iff (i_srst)
    in_cyc && !is_rf && !cur_r[`LBC_AD0_BIT] |-> !o_bhe_n)
    else $error("word transfer without upper enable");
  a_busy_hold: assert property (
    @(posedge i_clk) disable iff (i_srst)
    stall_r && st_r == LBC_IDLE |=> st_r == LBC_IDLE)
    else $error("cycle started while stalled");
  a_clk_half: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fall |=> o_clkout != $past(o_clkout))
    else $error("clock output missed a falling edge");
  a_den_data: assert property (
    @(posedge i_clk) disable iff (i_srst)
    !o_den_n |-> data_ph)
    else $error("transceiver enabled outside data");
  a_dir_write: assert property (
    @(posedge i_clk) disable iff (i_srst)
    in_cyc |-> o_transfer_direction == is_wr)
    else $error("direction wrong");
  a_den_refresh: assert property (
    @(posedge i_clk) disable iff (i_srst)
    in_cyc && is_rf |-> o_den_n)
    else $error("transceiver enabled in refresh");
  a_read_float: assert property (
    @(posedge i_clk) disable iff (i_srst)
    data_ph && !is_wr && !is_rf |-> o_ad_oe_n && !o_transfer_direction)
    else $error("bus driven during read data");
  a_done_t4: assert property (
    @(posedge i_clk) disable iff (i_srst)
    o_done |-> $past(st_r) == LBC_T4)
    else $error("done without a fourth state");
  a_read_pulse: assert property (
    @(posedge i_clk) disable iff (i_srst)
    o_rd_valid |-> o_done && !is_wr)
    else $error("read data flagged outside a read");
  a_addr_latch: assert property (
    @(posedge i_clk) disable iff (i_srst)
    st_r == LBC_T1 && tick |=>
      lat_r == $past(cur_r[`LBC_LAT_MSB:`LBC_LAT_LSB]))
    else $error("latched address bits wrong");
  c_read: cover property (@(posedge i_clk) rdv_r);
  c_wait: cover property (@(posedge i_clk) st_r == LBC_TW);
  c_stall: cover property (@(posedge i_clk) stall_r && cmd_valid);
  c_full: cover property (@(posedge i_clk) !o_req_ready);
  c_refresh: cover property (@(posedge i_clk) in_cyc && is_rf);
endmodule

// *** dv/lbc_mem_model.sv ***
`timescale 1ns/1ps
module lbc_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_ale,
  input  wire logic        i_den_n,
  input  wire logic        i_dir,
  input  wire logic [9:0]  i_wait,
  input  wire logic [15:0] i_rdata,
  output logic             o_ardy,
  output logic      [15:0] o_ad
);
  logic [9:0]  cnt_r  = 10'h000;
  logic [15:0] junk_r = 16'h0000;
  always @(posedge i_clk) begin
    cnt_r  <= i_ale ? 10'h000 : cnt_r + 10'h001;
    junk_r <= junk_r + 16'h3C5B;
  end
  // Ready is held back for a chosen count, which forces wait states.
  assign o_ardy = !i_ale && (cnt_r >= i_wait);
  // Outside its read phase the bus shows a moving pattern, never stale data.
  assign o_ad = (!i_den_n && !i_dir) ? i_rdata : junk_r;
endmodule

// *** dv/lbc_top_tb.sv ***
`timescale 1ns/1ps
`include "lbc_defs.svh"
module lbc_top_tb;
  logic i_clk = 1'b0, i_srst = 1'b1, i_clkin = 1'b0, i_enhanced = 1'b0;
  logic i_latch_addr_mode = 1'b0, i_coproc_op = 1'b0, i_req_valid = 1'b0;
  logic i_req_write = 1'b0, i_req_refresh = 1'b0, i_pcs5_int_n = 1'b1;
  logic i_pcs6_int_n = 1'b1, i_busy = 1'b0, i_ardy;
  logic i_dma_request_ch_zero = 1'b0, i_dma_request_ch_one = 1'b0;
  logic o_req_ready, o_rd_valid, o_done, o_stalled, o_clkout, o_ale;
  logic o_ad_oe_n, o_bhe_n, o_den_n, o_transfer_direction;
  logic o_peripheral_select_five_n, o_peripheral_select_six_n;
  logic [19:0] i_req_addr = 20'h00000;
  logic [15:0] i_req_wdata = 16'h0000, rdata = 16'h0000, i_ad, o_ad, o_rd_data;
  logic [15:0] ad_s, wd_s;
  logic [3:0]  i_req_status = 4'h0, o_upper_addr_status_pin, hi_s, st_s;
  logic [1:0]  o_dma_req;
  logic [9:0]  wait_c = 10'h000;
  logic        bhe_s, oe_s;
  int          miscompares = 0;
  int          n_checks = 0;

  lbc_top #(.DEPTH(`LBC_FIFO_DEPTH)) DUT (.i_clk, .i_srst, .i_clkin,
    .i_enhanced, .i_latch_addr_mode, .i_coproc_op, .i_req_valid, .o_req_ready,
    .i_req_addr, .i_req_wdata, .i_req_write, .i_req_refresh, .i_req_status,
    .i_pcs5_int_n, .i_pcs6_int_n, .o_rd_valid, .o_rd_data, .o_done,
    .o_stalled, .o_dma_req, .o_clkout, .o_ale, .o_ad, .o_ad_oe_n, .i_ad,
    .o_upper_addr_status_pin, .o_bhe_n, .o_den_n, .o_transfer_direction,
    .o_peripheral_select_five_n, .o_peripheral_select_six_n, .i_ardy, .i_busy,
    .i_dma_request_ch_zero, .i_dma_request_ch_one);
  lbc_mem_model u_mem (.i_clk(i_clk), .i_ale(o_ale), .i_den_n(o_den_n),
    .i_dir(o_transfer_direction), .i_wait(wait_c), .i_rdata(rdata),
    .o_ardy(i_ardy), .o_ad(i_ad));

  always #2 i_clk = ~i_clk;
  initial begin
    #7;
    forever #32 i_clkin = ~i_clkin;
  end
  // Pins are captured in the strobe state and in the data state.
  always @(posedge i_clk) begin
    if (o_ale) begin
      hi_s <= o_upper_addr_status_pin;
      ad_s <= o_ad;
      bhe_s <= o_bhe_n;
    end
    if (!o_den_n && !o_ale) begin
      st_s <= o_upper_addr_status_pin;
      if (o_transfer_direction) wd_s <= o_ad;
      oe_s <= o_ad_oe_n;
    end
  end

  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo(input string nm);
    $display("[ERR] %s expected handshake seen timeout", nm);
    miscompares++;
    conclude();
  endtask
  task automatic push(input logic [19:0] a, input logic [15:0] d,
                      input logic w, input logic rf);
    i_req_addr = a;
    i_req_wdata = d;
    i_req_write = w;
    i_req_refresh = rf;
    i_req_status = a[3:0] ^ 4'h9;
    i_req_valid = 1'b1;
    for (int k = 0; o_req_ready !== 1'b1; k++) begin
      if (k > 4000) tmo("req_ready");
      @(negedge i_clk);
    end
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask
  task automatic wt_done(output logic [15:0] rd, output logic rv);
    int k;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
      if (k > 6000) tmo("done");
    end while (o_done !== 1'b1);
    rd = o_rd_data;
    rv = o_rd_valid;
  endtask
  // An even byte cannot be asked for at these ports: requests carry no size.
  task automatic t_xfer(input logic [19:0] a, input logic [15:0] d,
                        input logic w, input logic rf, input logic [1:0] enc);
    logic [15:0] rd;
    logic        rv;
    rdata = ~d;
    push(a, d, w, rf);
    wt_done(rd, rv);
    chk("addr_hi", {16'h0000, a[19:16]}, {16'h0000, hi_s});
    chk("addr_lo", {4'h0, a[15:0]}, {4'h0, ad_s});
    chk("size", {18'h00000, enc}, {18'h00000, ad_s[0], bhe_s});
    if (!rf) begin
      chk("status", {16'h0000, a[3:0] ^ 4'h9}, {16'h0000, st_s});
      chk("rd_valid", {19'h00000, !w}, {19'h00000, rv});
      chk("bus_oe", {19'h00000, !w}, {19'h00000, oe_s});
      if (w) chk("wdata", {4'h0, d}, {4'h0, wd_s});
      else chk("rdata", {4'h0, ~d}, {4'h0, rd});
    end
  endtask
  task automatic t_stall;
    logic [15:0] rd;
    logic        rv;
    i_coproc_op = 1'b1;
    i_busy = 1'b1;
    for (int k = 0; o_stalled !== 1'b1; k++) begin
      if (k > 50) tmo("stall");
      @(negedge i_clk);
    end
    push(20'h00010, 16'h1111, 1'b1, 1'b0);
    repeat (300) begin
      @(negedge i_clk);
      chk("stall_ale", 20'h00000, {19'h00000, o_ale});
    end
    i_busy = 1'b0;
    wt_done(rd, rv);
    chk("stalled", 20'h00000, {19'h00000, o_stalled});
    i_coproc_op = 1'b0;
  endtask
  task automatic t_dma;
    for (int j = 1; j < 4; j++) begin
      {i_dma_request_ch_one, i_dma_request_ch_zero} = j[1:0];
      @(negedge i_clk);
      chk("dma_sync", 20'(j - 1), {18'h00000, o_dma_req});
      repeat (8) @(negedge i_clk);
      chk("dma_level", 20'(j), {18'h00000, o_dma_req});
    end
  endtask
  task automatic t_clk;
    int   tg, hi;
    logic p;
    tg = 0;
    hi = 0;
    p = o_clkout;
    repeat (1024) begin
      @(negedge i_clk);
      tg += int'(o_clkout !== p);
      hi += int'(o_clkout === 1'b1);
      p = o_clkout;
    end
    chk("clk_rate", 20'h00001,
        {19'h00000, tg >= 63 && tg <= 65});
    chk("clk_duty", 20'h00001, {19'h00000, hi >= 496 && hi <= 528});
  endtask
  task automatic t_lmode;
    i_pcs5_int_n = 1'b0;
    @(negedge i_clk);
    chk("sel_norm", 20'h00001, {18'h00000, o_peripheral_select_five_n,
        o_peripheral_select_six_n});
    i_latch_addr_mode = 1'b1;
    t_xfer(20'h40002, 16'hC0DE, 1'b1, 1'b0, 2'b00);
    chk("sel_latch", 20'h00002, {18'h00000, o_peripheral_select_five_n,
        o_peripheral_select_six_n});
    i_latch_addr_mode = 1'b0;
  endtask
  task automatic t_fifo;
    int          acc;
    logic [15:0] rd;
    logic        rv;
    acc = 0;
    wait_c = 10'd40;
    i_req_write = 1'b1;
    i_req_valid = 1'b1;
    repeat (60) begin
      acc += int'(o_req_ready === 1'b1);
      @(negedge i_clk);
    end
    i_req_valid = 1'b0;
    chk("fifo_full", 20'h00000, {19'h00000, o_req_ready});
    chk("fifo_fill", 20'h00001, {19'h00000, acc >= 16 && acc <= 17});
    repeat (acc) wt_done(rd, rv);
    chk("fifo_empty", 20'h00001, {19'h00000, o_req_ready});
  endtask

  initial begin
    repeat (20) @(negedge i_clk);
    i_srst = 1'b0;
    t_xfer(20'hA1234, 16'h5AC3, 1'b1, 1'b0, 2'b00);
    wait_c = 10'd150;
    t_xfer(20'h3BCD7, 16'h0F1E, 1'b0, 1'b0, 2'b10);
    i_enhanced = 1'b1;
    t_xfer(20'h50021, 16'h0000, 1'b0, 1'b1, 2'b11);
    t_stall();
    t_dma();
    t_clk();
    t_lmode();
    t_fifo();
    conclude();
  end
endmodule
